// ===== supply_monitor_irq_bank.sv
// Purpose: supply monitor control plus primary/shared interrupt registers
// Assumes: analog comparator and pins are asynchronous; events are pulses
// Notes:   APB slave, zero wait states, one register per 32-bit word
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "supply_irq_consts.svh"

// Behaviour
// - three-bit trip level field, bits 2..0, code 111 is highest level
// - read-only supply-low out flag in bit 5, 1 when below threshold while the detector is active
// - monitor enable bit 4 switches detector on, 0 switches it off
// - detector held off during sleep regardless of the enable bit
// - supply-low request set only after fixed delay of flag high
// - supply-low request is served through shared interrupt two
// - new supply-low request during idle wakes the device
// - pending enabled request diverts the core to its source routine
// - two pin interrupts plus timers, time bases, monitor, eeprom etc
// - three primary, three shared and one edge select register
// - edge register: pin one bits 3..2, pin zero bits 1..0
// - primary 0: shared0, comparator, pin0 flags, enables, global
// - primary 1: timebase0, converter, shared2, shared1 flags, enables
// - primary 2: async, sync serial, pin1, timebase1 flags, enables
// - shared 0: standard timer match and period flags and enables
// - shared 1: compact and periodic timer flags and enables
// - shared 2: eeprom and supply-low flags and enables
// - edge codes: 00 off, 01 rising, 10 falling, 11 both
// - flag 1 means pending; enable 1 permits, 0 blocks
module supply_monitor_irq_bank #(
   parameter int DELAY_CYC = `SUPPLY_LOW_IRQ_DELAY_CYC
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                supply_below_raw,
   input  wire logic                sleep_mode,
   input  wire logic                idle_mode,
   input  wire logic                ext_pin_irq_zero,
   input  wire logic                ext_pin_irq_one,
   input  wire logic                comparator_evt,
   input  wire logic                converter_evt,
   input  wire logic [1:0]          timebase_evt,
   input  wire logic                sync_serial_evt,
   input  wire logic                async_serial_evt,
   input  wire logic [1:0]          std_timer_evt,
   input  wire logic [3:0]          comp_per_timer_evt,
   input  wire logic                eeprom_evt,
   input  wire logic                irq_ack,
   output logic                     monitor_active,
   output logic [2:0]               trip_level_select,
   output logic                     irq_req,
   output supply_irq_pkg::irq_src_t irq_src,
   output logic                     idle_wake
);

   logic [7:0] ctrl_q;
   logic [7:0] edge_q;
   logic [7:0] irq_q [6];
   logic [7:0] hw_set [6];
   logic [7:0] ack_clr [6];
   logic [7:0] wr_mask [6];

   logic       low_s1_q;
   logic       low_s2_q;
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [1:0] pin_prev_q;
   logic [1:0] pin_edge;

   logic       supply_low_out;
   logic [15:0] delay_cnt_q;
   supply_irq_pkg::low_state_t low_state_q;
   logic       low_fire;

   logic        acc_wr;
   logic        setup_rd;
   logic [2:0]  sel_idx;
   logic        mapped;
   logic [7:0]  rd_byte;
   logic [10:0] pending;
   supply_irq_pkg::irq_src_t pick;
   logic        irq_req_q;
   supply_irq_pkg::irq_src_t irq_src_q;
   logic        idle_wake_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   // apb decode
   always_comb begin
      mapped  = 1'b1;
      sel_idx = 3'h0;
      case (paddr)
         `OFS_SUPPLY_MONITOR_CTRL: sel_idx = 3'h0;
         `OFS_EXT_EDGE_SELECT:     sel_idx = 3'h1;
         `OFS_PRIMARY_IRQ_0:       sel_idx = 3'h2;
         `OFS_PRIMARY_IRQ_1:       sel_idx = 3'h3;
         `OFS_PRIMARY_IRQ_2:       sel_idx = 3'h4;
         `OFS_SHARED_IRQ_0:        sel_idx = 3'h5;
         `OFS_SHARED_IRQ_1:        sel_idx = 3'h6;
         `OFS_SHARED_IRQ_2:        sel_idx = 3'h7;
         default:                  mapped  = 1'b0;
      endcase
   end

   assign acc_wr   = psel & penable & pwrite & mapped;
   assign setup_rd = psel & ~penable;
   assign pready   = psel & penable;
   assign prdata   = prdata_q;
   assign pslverr  = pslverr_q & pready;

   always_comb begin
      case (sel_idx)
         3'h0: begin
            rd_byte = ctrl_q & `CTRL_WRITE_MASK;
            rd_byte[`CTRL_LOW_OUT_BIT] = supply_low_out;
         end
         3'h1:    rd_byte = edge_q;
         3'h2:    rd_byte = irq_q[0];
         3'h3:    rd_byte = irq_q[1];
         3'h4:    rd_byte = irq_q[2];
         3'h5:    rd_byte = irq_q[3];
         3'h6:    rd_byte = irq_q[4];
         default: rd_byte = irq_q[5];
      endcase
   end

   // read data caught in setup so the access phase sees a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup_rd) begin
         prdata_q  <= (mapped && !pwrite) ? {24'h00_0000, rd_byte}
                                         : 32'h0000_0000;
         pslverr_q <= ~mapped;
      end
   end

   // supply monitor control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `REG_RESET;
      end else if (acc_wr && sel_idx == 3'h0) begin
         ctrl_q <= pwdata[7:0] & `CTRL_WRITE_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_q <= `REG_RESET;
      end else if (acc_wr && sel_idx == 3'h1) begin
         edge_q <= pwdata[7:0] & `EDGE_WRITE_MASK;
      end
   end

   assign trip_level_select = ctrl_q[`CTRL_TRIP_LSB +: 3];
   // sleep overrides enable so the analog part draws nothing
   assign monitor_active = ctrl_q[`CTRL_ENABLE_BIT] & ~sleep_mode;

   // comparator and pins come from outside the clock domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_s1_q   <= 1'b0;
         low_s2_q   <= 1'b0;
         pin_s1_q   <= 2'b00;
         pin_s2_q   <= 2'b00;
         pin_prev_q <= 2'b00;
      end else begin
         low_s1_q   <= supply_below_raw;
         low_s2_q   <= low_s1_q;
         pin_s1_q   <= {ext_pin_irq_one, ext_pin_irq_zero};
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // unfiltered: near the threshold this toggles, software copes
   assign supply_low_out = low_s2_q & monitor_active;

   // per-pin edge qualification
   for (genvar p = 0; p < 2; p++) begin : g_pin
      logic [1:0] sel;
      logic       rise;
      logic       fall;
      assign sel  = edge_q[2*p +: 2];
      assign rise = pin_s2_q[p] & ~pin_prev_q[p];
      assign fall = ~pin_s2_q[p] & pin_prev_q[p];
      always_comb begin
         case (supply_irq_pkg::edge_sel_t'(sel))
            supply_irq_pkg::EDGE_RISE: pin_edge[p] = rise;
            supply_irq_pkg::EDGE_FALL: pin_edge[p] = fall;
            supply_irq_pkg::EDGE_BOTH: pin_edge[p] = rise | fall;
            default:                   pin_edge[p] = 1'b0;
         endcase
      end
   end

   // delay from low flag rising to the request, once per low episode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_cnt_q <= 16'h0000;
         low_state_q <= supply_irq_pkg::LOW_WAIT;
      end else if (!supply_low_out) begin
         delay_cnt_q <= 16'h0000;
         low_state_q <= supply_irq_pkg::LOW_WAIT;
      end else begin
         case (low_state_q)
            supply_irq_pkg::LOW_WAIT: begin
               if (delay_cnt_q == 16'(DELAY_CYC - 1)) begin
                  low_state_q <= supply_irq_pkg::LOW_DONE;
               end else begin
                  delay_cnt_q <= delay_cnt_q + 16'h0001;
               end
            end
            default: low_state_q <= supply_irq_pkg::LOW_DONE;
         endcase
      end
   end

   assign low_fire = supply_low_out &
                     (low_state_q == supply_irq_pkg::LOW_WAIT) &
                     (delay_cnt_q == 16'(DELAY_CYC - 1));

   // hardware set terms per register
   always_comb begin
      for (int r = 0; r < 6; r++) begin
         hw_set[r] = 8'h00;
      end
      // shared flags follow any enabled member flag
      hw_set[0][6] = |(irq_q[3][5:4] & irq_q[3][1:0]);
      hw_set[0][5] = comparator_evt;
      hw_set[0][4] = pin_edge[0];
      hw_set[1][7] = timebase_evt[0];
      hw_set[1][6] = converter_evt;
      hw_set[1][5] = |(irq_q[5][5:4] & irq_q[5][1:0]);
      hw_set[1][4] = |(irq_q[4][7:4] & irq_q[4][3:0]);
      hw_set[2][7] = async_serial_evt;
      hw_set[2][6] = sync_serial_evt;
      hw_set[2][5] = pin_edge[1];
      hw_set[2][4] = timebase_evt[1];
      hw_set[3][5:4] = std_timer_evt;
      hw_set[4][7:4] = comp_per_timer_evt;
      hw_set[5][5] = eeprom_evt;
      hw_set[5][4] = low_fire;
   end

   // acknowledged source flag is cleared
   always_comb begin
      for (int r = 0; r < 6; r++) begin
         ack_clr[r] = 8'h00;
      end
      if (irq_ack) begin
         case (irq_src_q)
            supply_irq_pkg::SRC_PIN_ZERO:     ack_clr[0][4] = 1'b1;
            supply_irq_pkg::SRC_COMPARATOR:   ack_clr[0][5] = 1'b1;
            supply_irq_pkg::SRC_SHARED0:      ack_clr[0][6] = 1'b1;
            supply_irq_pkg::SRC_SHARED1:      ack_clr[1][4] = 1'b1;
            supply_irq_pkg::SRC_SHARED2:      ack_clr[1][5] = 1'b1;
            supply_irq_pkg::SRC_CONVERTER:    ack_clr[1][6] = 1'b1;
            supply_irq_pkg::SRC_TIMEBASE0:    ack_clr[1][7] = 1'b1;
            supply_irq_pkg::SRC_TIMEBASE1:    ack_clr[2][4] = 1'b1;
            supply_irq_pkg::SRC_PIN_ONE:      ack_clr[2][5] = 1'b1;
            supply_irq_pkg::SRC_SYNC_SERIAL:  ack_clr[2][6] = 1'b1;
            supply_irq_pkg::SRC_ASYNC_SERIAL: ack_clr[2][7] = 1'b1;
            default:                          ack_clr[0] = 8'h00;
         endcase
      end
   end

   assign wr_mask[0] = `PRIMARY0_WRITE_MASK;
   assign wr_mask[1] = `FULL_WRITE_MASK;
   assign wr_mask[2] = `FULL_WRITE_MASK;
   assign wr_mask[3] = `SHARED_NARROW_MASK;
   assign wr_mask[4] = `FULL_WRITE_MASK;
   assign wr_mask[5] = `SHARED_NARROW_MASK;

   // flag and enable registers; hardware set beats any clear
   for (genvar r = 0; r < 6; r++) begin : g_irq
      logic       hit;
      logic [7:0] base;
      assign hit  = acc_wr && (sel_idx == 3'(r + 2));
      assign base = hit ? (pwdata[7:0] & wr_mask[r])
                        : (irq_q[r] & ~ack_clr[r]);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            irq_q[r] <= `REG_RESET;
         end else begin
            irq_q[r] <= base | (hw_set[r] & wr_mask[r]);
         end
      end
   end

   // pending = flag and enable, gated by global enable
   always_comb begin
      pending[0]  = irq_q[0][4] & irq_q[0][1];
      pending[1]  = irq_q[0][5] & irq_q[0][2];
      pending[2]  = irq_q[0][6] & irq_q[0][3];
      pending[3]  = irq_q[1][4] & irq_q[1][0];
      pending[4]  = irq_q[1][5] & irq_q[1][1];
      pending[5]  = irq_q[1][6] & irq_q[1][2];
      pending[6]  = irq_q[1][7] & irq_q[1][3];
      pending[7]  = irq_q[2][4] & irq_q[2][0];
      pending[8]  = irq_q[2][5] & irq_q[2][1];
      pending[9]  = irq_q[2][6] & irq_q[2][2];
      pending[10] = irq_q[2][7] & irq_q[2][3];
      if (!irq_q[0][0]) begin
         pending = 11'h000;
      end
   end

   // fixed priority, lowest index wins
   always_comb begin
      pick = supply_irq_pkg::SRC_NONE;
      for (int i = 10; i >= 0; i--) begin
         if (pending[i]) begin
            pick = supply_irq_pkg::irq_src_t'(4'(i));
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req_q <= 1'b0;
         irq_src_q <= supply_irq_pkg::SRC_NONE;
      end else begin
         irq_req_q <= |pending & ~irq_ack;
         irq_src_q <= irq_ack ? supply_irq_pkg::SRC_NONE : pick;
      end
   end

   assign irq_req = irq_req_q;
   assign irq_src = irq_src_q;

   // only a fresh request wakes; a preset flag suppresses it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_wake_q <= 1'b0;
      end else begin
         idle_wake_q <= idle_mode & low_fire & ~irq_q[5][4];
      end
   end

   assign idle_wake = idle_wake_q;

endmodule : supply_monitor_irq_bank

// ===== supply_irq_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   definitions only
`ifndef SUPPLY_IRQ_CONSTS_SVH
`define SUPPLY_IRQ_CONSTS_SVH

`define OFS_SUPPLY_MONITOR_CTRL 12'h000
`define OFS_EXT_EDGE_SELECT     12'h004
`define OFS_PRIMARY_IRQ_0       12'h008
`define OFS_PRIMARY_IRQ_1       12'h00C
`define OFS_PRIMARY_IRQ_2       12'h010
`define OFS_SHARED_IRQ_0        12'h014
`define OFS_SHARED_IRQ_1        12'h018
`define OFS_SHARED_IRQ_2        12'h01C

`define CTRL_TRIP_LSB           0
`define CTRL_ENABLE_BIT         4
`define CTRL_LOW_OUT_BIT        5
`define CTRL_WRITE_MASK         8'h17
`define EDGE_WRITE_MASK         8'h0F
`define PRIMARY0_WRITE_MASK     8'h7F
`define FULL_WRITE_MASK         8'hFF
`define SHARED_NARROW_MASK      8'h33

`define REG_RESET               8'h00

`define CLK_PERIOD_NS           10
`define SUPPLY_LOW_IRQ_DELAY_NS 1000
`define SUPPLY_LOW_IRQ_DELAY_CYC \
   (`SUPPLY_LOW_IRQ_DELAY_NS / `CLK_PERIOD_NS)

`endif

// ===== supply_irq_pkg.sv
// Purpose: shared types of the supply monitor and interrupt bank
// Assumes: nothing
// Notes:   numeric constants live in supply_irq_consts.svh
package supply_irq_pkg;

   typedef enum logic [3:0] {
      SRC_PIN_ZERO,
      SRC_COMPARATOR,
      SRC_SHARED0,
      SRC_SHARED1,
      SRC_SHARED2,
      SRC_CONVERTER,
      SRC_TIMEBASE0,
      SRC_TIMEBASE1,
      SRC_PIN_ONE,
      SRC_SYNC_SERIAL,
      SRC_ASYNC_SERIAL,
      SRC_NONE
   } irq_src_t;

   typedef enum logic [1:0] {
      EDGE_OFF,
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } edge_sel_t;

   typedef enum logic [0:0] {
      LOW_WAIT,
      LOW_DONE
   } low_state_t;

endpackage : supply_irq_pkg

// ===== supply_irq_bank_chk.sv
// Purpose: port assertions for the supply monitor interrupt bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every instance at the foot of this file
`timescale 1ns/10ps
`include "supply_irq_consts.svh"
module supply_irq_bank_chk (
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [11:0]              paddr,
   input wire logic [31:0]              pwdata,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic                     sleep_mode,
   input wire logic                     irq_ack,
   input wire logic                     monitor_active,
   input wire logic [2:0]               trip_level_select,
   input wire logic                     irq_req,
   input wire supply_irq_pkg::irq_src_t irq_src,
   input wire logic                     idle_wake
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_now:
      assert property (pready == (psel && penable))
         else $error("pready not in access phase");
   a_err_access:
      assert property (pslverr |-> pready && prdata == 32'h0)
         else $error("error response outside access or nonzero data");
   a_upper_zero:
      assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
         else $error("upper read bits not zero");
   a_trip_by_write:
      assert property ($changed(trip_level_select) |-> $past(psel &&
         penable && pwrite && paddr == `OFS_SUPPLY_MONITOR_CTRL))
         else $error("trip level changed without a write");
   a_trip_follows:
      assert property (psel && penable && pwrite &&
         paddr == `OFS_SUPPLY_MONITOR_CTRL
         |=> trip_level_select == $past(pwdata[2:0]))
         else $error("trip level not taken from write");
   a_sleep_off:
      assert property (sleep_mode |-> !monitor_active)
         else $error("detector active in sleep");
   a_src_valid:
      assert property (irq_req |-> irq_src != supply_irq_pkg::SRC_NONE)
         else $error("request without source");
   a_ack_drop:
      assert property (irq_ack && irq_req |=> !irq_req)
         else $error("request held over acknowledge");
   a_wake_pulse:
      assert property (idle_wake |=> !idle_wake)
         else $error("wake longer than one cycle");
   c_ack: cover property (irq_ack && irq_req);
   c_wake: cover property (idle_wake);
   c_err: cover property (pslverr);
endmodule : supply_irq_bank_chk

bind supply_monitor_irq_bank supply_irq_bank_chk supply_irq_bank_chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
   .irq_ack(irq_ack), .monitor_active(monitor_active),
   .trip_level_select(trip_level_select), .irq_req(irq_req),
   .irq_src(irq_src), .idle_wake(idle_wake));

// ===== tb_top.sv
// Purpose: self-checking bench for the supply monitor interrupt bank
// Assumes: zero-wait APB slave, delay count shortened to 3
// Notes:   scenarios run in sequence, one task each
`timescale 1ns/10ps
`include "supply_irq_consts.svh"
module tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        raw = 1'b0;
   logic        sleep = 1'b0;
   logic        idle = 1'b0;
   logic [1:0]  pin = 2'h0;
   logic [12:0] evt = 13'h0;
   logic        irq_ack = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, monitor_active, irq_req, idle_wake;
   logic [2:0]  trip_level_select;
   supply_irq_pkg::irq_src_t irq_src;
   int          errors = 0;
   int          checks = 0;
   int          cycles = 0;
   int          wakes = 0;

   supply_monitor_irq_bank #(.DELAY_CYC(3)) supply_monitor_irq_bank_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .supply_below_raw(raw),
      .sleep_mode(sleep), .idle_mode(idle), .ext_pin_irq_zero(pin[0]),
      .ext_pin_irq_one(pin[1]), .comparator_evt(evt[0]),
      .converter_evt(evt[1]), .timebase_evt(evt[3:2]),
      .sync_serial_evt(evt[4]), .async_serial_evt(evt[5]),
      .std_timer_evt(evt[7:6]), .comp_per_timer_evt(evt[11:8]),
      .eeprom_evt(evt[12]), .irq_ack(irq_ack),
      .monitor_active(monitor_active),
      .trip_level_select(trip_level_select), .irq_req(irq_req),
      .irq_src(irq_src), .idle_wake(idle_wake));

   always #5 pclk = ~pclk;

   task automatic test_done;
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // hang guard, generous against a run of several hundred cycles
   always @(posedge pclk) begin
      cycles++;
      if (idle_wake === 1'b1)
         wakes++;
      if (cycles == 20000) begin
         errors++;
         test_done;
      end
   end

   task automatic chk(input string w, input logic [31:0] s,
                      input logic [31:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", w, e, s);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, output logic [31:0] rd,
                      output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a stalled access
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] x;
      logic        e;
      apb(1'b1, a, d, x, e);
   endtask : wr

   task automatic rc(input string w, input logic [11:0] a,
                     input logic [7:0] v);
      logic [31:0] x;
      logic        e;
      apb(1'b0, a, 8'h00, x, e);
      chk(w, x, {24'h0, v});
   endtask : rc

   // shared registers first, else the primary flags are re-raised
   task automatic clr;
      for (int i = 7; i >= 0; i--)
         wr(12'(4 * i), 8'h00);
   endtask : clr

   task automatic ack;
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      cyc(2);
   endtask : ack

   task automatic t_masks;
      logic [7:0]  m [8];
      logic [31:0] x;
      logic        e;
      m = '{8'h17, 8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h33};
      for (int i = 0; i < 8; i++) begin
         rc("reset", 12'(4 * i), 8'h00);
         wr(12'(4 * i), 8'hFF);
         rc("mask", 12'(4 * i), m[i]);
      end
      chk("trip", trip_level_select, 32'h7);
      apb(1'b0, 12'h020, 8'h00, x, e);
      chk("err", e, 32'h1);
      chk("unmapped", x, 32'h0);
      clr;
      for (int i = 0; i < 8; i++)
         rc("clear", 12'(4 * i), 8'h00);
   endtask : t_masks

   task automatic t_events;
      logic [7:0] m [8];
      m = '{8'h00, 8'h00, 8'h20, 8'hC0, 8'hD0, 8'h30, 8'hF0, 8'h20};
      evt <= 13'h1FFF;
      @(posedge pclk);
      evt <= 13'h0000;
      cyc(4);
      for (int i = 2; i < 8; i++)
         rc("event", 12'(4 * i), m[i]);
      clr;
   endtask : t_events

   task automatic t_pins;
      logic [11:0] fa;
      logic [7:0]  fb;
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 4; c++) begin
            fa = p ? `OFS_PRIMARY_IRQ_2 : `OFS_PRIMARY_IRQ_0;
            fb = p ? 8'h20 : 8'h10;
            wr(`OFS_EXT_EDGE_SELECT, 8'(c << (2 * p)));
            pin[p] <= 1'b1;
            cyc(6);
            rc("rise", fa, c[0] ? fb : 8'h00);
            wr(fa, 8'h00);
            pin[p] <= 1'b0;
            cyc(6);
            rc("fall", fa, c[1] ? fb : 8'h00);
            wr(fa, 8'h00);
         end
   endtask : t_pins

   task automatic t_core;
      wr(`OFS_PRIMARY_IRQ_0, 8'h37);
      cyc(2);
      chk("req", irq_req, 32'h1);
      chk("src", irq_src, supply_irq_pkg::SRC_PIN_ZERO);
      ack;
      chk("src", irq_src, supply_irq_pkg::SRC_COMPARATOR);
      ack;
      chk("req", irq_req, 32'h0);
      rc("acked", `OFS_PRIMARY_IRQ_0, 8'h07);
      wr(`OFS_PRIMARY_IRQ_0, 8'h26);
      cyc(2);
      chk("global", irq_req, 32'h0);
      clr;
   endtask : t_core

   task automatic t_lvd;
      int n;
      int w0;
      n = 0;
      wr(`OFS_SHARED_IRQ_2, 8'h01);
      wr(`OFS_PRIMARY_IRQ_1, 8'h02);
      wr(`OFS_PRIMARY_IRQ_0, 8'h01);
      wr(`OFS_SUPPLY_MONITOR_CTRL, 8'h13);
      idle <= 1'b1;
      raw <= 1'b1;
      rc("early", `OFS_SHARED_IRQ_2, 8'h01);
      while (idle_wake !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk("wake", idle_wake, 32'h1);
      rc("lvf", `OFS_SHARED_IRQ_2, 8'h11);
      rc("low", `OFS_SUPPLY_MONITOR_CTRL, 8'h33);
      rc("shared", `OFS_PRIMARY_IRQ_1, 8'h22);
      chk("src", irq_src, supply_irq_pkg::SRC_SHARED2);
      sleep <= 1'b1;
      cyc(3);
      chk("sleep", monitor_active, 32'h0);
      rc("sleep", `OFS_SUPPLY_MONITOR_CTRL, 8'h13);
      sleep <= 1'b0;
      wr(`OFS_SUPPLY_MONITOR_CTRL, 8'h03);
      cyc(3);
      rc("off", `OFS_SUPPLY_MONITOR_CTRL, 8'h03);
      wr(`OFS_SHARED_IRQ_2, 8'h11);
      w0 = wakes;
      wr(`OFS_SUPPLY_MONITOR_CTRL, 8'h13);
      cyc(12);
      // settle time passed before the low flag is trusted
      rc("settled", `OFS_SUPPLY_MONITOR_CTRL, 8'h33);
      raw <= 1'b0;
      cyc(3);
      rc("toggle", `OFS_SUPPLY_MONITOR_CTRL, 8'h13);
      raw <= 1'b1;
      cyc(12);
      chk("nowake", wakes, w0);
      raw <= 1'b0;
      idle <= 1'b0;
      clr;
   endtask : t_lvd

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_masks;
      t_events;
      t_pins;
      t_core;
      t_lvd;
      test_done;
   end
endmodule : tb_top
